// ===== rtl/fsirq_defs.vh
// register offsets, field positions and reset values for the fifo and slot irq status block
`ifndef FSIRQ_DEFS_VH
`define FSIRQ_DEFS_VH

`define FSIRQ_ADDR_W          8
`define FSIRQ_STATUS_ADDR     8'h00
`define FSIRQ_MASK_ADDR       8'h01
`define FSIRQ_THRESH_ADDR     8'h06

`define FSIRQ_CNT_MSB         15
`define FSIRQ_CNT_LSB         8
`define FSIRQ_FLUSH_BIT       15
`define FSIRQ_RSV7_BIT        7
`define FSIRQ_SECOND_BIT      6
`define FSIRQ_FIRST_BIT       5
`define FSIRQ_RSVLO_MSB       4
`define FSIRQ_RSVLO_CLR       5'h1F

`define FSIRQ_FIFO_MASK_BIT   8
`define FSIRQ_MASK_RESET      16'h01FF
`define FSIRQ_MASK_RW         16'h01FF

`define FSIRQ_THR_MSB         13
`define FSIRQ_THR_LSB         8
`define FSIRQ_THR_RESET       6'h00

`endif

// ===== rtl/fsirq_status.v
// status flags, fifo byte count, word threshold and interrupt masking
// Function
// - status bits 15:8 report bytes available in the output fifo
// - byte count compares against threshold in words, one word being two bytes
// - writing one to status bit 15 empties the fifo, count becomes zero
// - reserved status bit 7 clears to zero when one is written
// - second slot sample event sets status bit 6, held until cleared
// - first slot sample event sets status bit 5, held until cleared
// - writing one clears a slot flag, writing zero leaves it alone
// - reserved status bits 4:0 clear when 0x1F is written
// - mask bit 8 gates the fifo level interrupt, resets to one
// - fifo level interrupt raised when fifo words exceed six bit threshold
// - mask bit 6 disables second slot interrupt, resets to one
// - mask bit 5 disables first slot interrupt, resets to one
// - fifo level interrupt drops by itself once words no longer exceed threshold
`include "fsirq_defs.vh"
`default_nettype none

module fsirq_status (
    input  wire        clk,          // 25 MHz clock
    input  wire        reset,        // synchronous, active high
    input  wire [7:0]  regAddr,      // register index
    input  wire        regWrite,     // one-cycle write strobe
    input  wire        regRead,      // read strobe, data next cycle
    input  wire [15:0] regWdata,     // write data
    output reg  [15:0] regRdata,     // read data
    input  wire        fifoPush,     // one byte enters the fifo
    input  wire        fifoPop,      // one byte leaves the fifo
    input  wire        secondSlotEvent, // second slot sample done pulse
    input  wire        firstSlotEvent,  // first slot sample done pulse
    output wire        fifoFlush,    // pulse: discard fifo contents
    output wire        irq           // interrupt request, active high
);

    reg  [7:0]  fifoByteCount;
    reg         reservedBit7;
    reg         secondSlotEventFlag;
    reg         firstSlotEventFlag;
    reg  [4:0]  reservedLow;
    reg  [15:0] interruptDisableMask;
    reg  [5:0]  fifoWordLimit;
    wire        statusWrite;
    wire        maskWrite;
    wire        threshWrite;
    wire        fifoLevelHigh;
    reg  [15:0] next_rdata;

    assign statusWrite = regWrite && (regAddr == `FSIRQ_STATUS_ADDR);
    assign maskWrite   = regWrite && (regAddr == `FSIRQ_MASK_ADDR);
    assign threshWrite = regWrite && (regAddr == `FSIRQ_THRESH_ADDR);
    assign fifoFlush   = statusWrite && regWdata[`FSIRQ_FLUSH_BIT];

    // byte count, flush overrides concurrent push/pop
    always @(posedge clk) begin
        if (reset) begin
            fifoByteCount <= 8'h00;
        end else if (fifoFlush) begin
            fifoByteCount <= 8'h00;
        end else if (fifoPush && !fifoPop && fifoByteCount != 8'hFF) begin
            fifoByteCount <= fifoByteCount + 8'h01;
        end else if (fifoPop && !fifoPush && fifoByteCount != 8'h00) begin
            fifoByteCount <= fifoByteCount - 8'h01;
        end
    end

    // sticky flags: an event in the clearing cycle wins
    always @(posedge clk) begin
        if (reset) begin
            reservedBit7        <= 1'b0;
            secondSlotEventFlag <= 1'b0;
            firstSlotEventFlag  <= 1'b0;
            reservedLow         <= 5'h00;
        end else begin
            if (statusWrite && regWdata[`FSIRQ_RSV7_BIT]) begin
                reservedBit7 <= 1'b0;
            end
            if (secondSlotEvent) begin
                secondSlotEventFlag <= 1'b1;
            end else if (statusWrite && regWdata[`FSIRQ_SECOND_BIT]) begin
                secondSlotEventFlag <= 1'b0;
            end
            if (firstSlotEvent) begin
                firstSlotEventFlag <= 1'b1;
            end else if (statusWrite && regWdata[`FSIRQ_FIRST_BIT]) begin
                firstSlotEventFlag <= 1'b0;
            end
            if (statusWrite && regWdata[`FSIRQ_RSVLO_MSB:0] == `FSIRQ_RSVLO_CLR) begin
                reservedLow <= 5'h00;
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            interruptDisableMask <= `FSIRQ_MASK_RESET;
            fifoWordLimit        <= `FSIRQ_THR_RESET;
        end else begin
            if (maskWrite) begin
                interruptDisableMask <= regWdata & `FSIRQ_MASK_RW;
            end
            if (threshWrite) begin
                fifoWordLimit <= regWdata[`FSIRQ_THR_MSB:`FSIRQ_THR_LSB];
            end
        end
    end

    // whole words available compared to the word threshold
    assign fifoLevelHigh = ({1'b0, fifoByteCount[7:1]} > {2'b00, fifoWordLimit});

    assign irq = (fifoLevelHigh && !interruptDisableMask[`FSIRQ_FIFO_MASK_BIT])
              || (secondSlotEventFlag && !interruptDisableMask[`FSIRQ_SECOND_BIT])
              || (firstSlotEventFlag && !interruptDisableMask[`FSIRQ_FIRST_BIT]);

    always @* begin
        case (regAddr)
            `FSIRQ_STATUS_ADDR: next_rdata = {fifoByteCount, reservedBit7, secondSlotEventFlag,
                                              firstSlotEventFlag, reservedLow};
            `FSIRQ_MASK_ADDR:   next_rdata = interruptDisableMask;
            `FSIRQ_THRESH_ADDR: next_rdata = {2'b00, fifoWordLimit, 8'h00};
            default:            next_rdata = 16'h0000;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            regRdata <= 16'h0000;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end
    end

endmodule // fsirq_status

`default_nettype wire

// ===== verification/fsirq_status_sva.sv
// port-level assertions for the fifo and slot irq status block
`default_nettype none
module fsirq_status_sva (
    input wire logic        clk, reset, regWrite, regRead, fifoPush, // control
    input wire logic        secondSlotEvent, firstSlotEvent, fifoFlush, irq, // events
    input wire logic [7:0]  regAddr,            // index
    input wire logic [15:0] regWdata, regRdata  // data
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_rd; regRead && regAddr == 8'h00 && !regWrite; endsequence
    sequence s_wr; regWrite && regAddr == 8'h00; endsequence
    property p_flush; fifoFlush == (regWrite && regAddr == 8'h00 && regWdata[15]); endproperty
    a_flush: assert property (p_flush) else $error("flush pulse wrong");
    property p_empty; (s_wr ##0 (regWdata[15] && !fifoPush)) ##1 s_rd |=> regRdata[15:8] == 8'h00; endproperty
    a_empty: assert property (p_empty) else $error("count not zero after flush");
    property p_rsv; s_rd |=> regRdata[7] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("bit 7 set");
    property p_rlo; s_rd |=> regRdata[4:0] == 5'h00; endproperty
    a_rlo: assert property (p_rlo) else $error("low bits set");
    property p_set2; secondSlotEvent ##1 s_rd |=> regRdata[6]; endproperty
    a_set2: assert property (p_set2) else $error("second flag not set");
    property p_set1; firstSlotEvent ##1 s_rd |=> regRdata[5]; endproperty
    a_set1: assert property (p_set1) else $error("first flag not set");
    property p_clr; (s_wr ##0 (regWdata[6] && !secondSlotEvent)) ##1 s_rd |=> !regRdata[6]; endproperty
    a_clr: assert property (p_clr) else $error("second flag not cleared");
    property p_clr1; (s_wr ##0 (regWdata[5] && !firstSlotEvent)) ##1 s_rd |=> !regRdata[5]; endproperty
    a_clr1: assert property (p_clr1) else $error("first flag not cleared");
    property p_mskhi; regRead && regAddr == 8'h01 |=> regRdata[15:9] == 7'h00; endproperty
    a_mskhi: assert property (p_mskhi) else $error("mask upper bits set");
    property p_rstirq; $fell(reset) |-> !irq; endproperty
    a_rstirq: assert property (p_rstirq) else $error("irq after reset");
endmodule // fsirq_status_sva
bind fsirq_status fsirq_status_sva i_sva (.clk, .reset, .regWrite, .regRead, .fifoPush, .secondSlotEvent,
    .firstSlotEvent, .fifoFlush, .irq, .regAddr, .regWdata, .regRdata);
`default_nettype wire

// ===== verification/fsirq_status_tb.sv
// self-checking bench for the fifo and slot irq status block
`default_nettype none
module fsirq_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, regWrite = 0, regRead = 0, fifoPush = 0, fifoPop = 0;
    logic secondSlotEvent = 0, firstSlotEvent = 0, fifoFlush, irq;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000, regRdata;
    int num_errors = 0, total_checks = 0, seed = 80239, cyc = 0, n;
    fsirq_status i_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .fifoPush(fifoPush), .fifoPop(fifoPop),
        .secondSlotEvent(secondSlotEvent), .firstSlotEvent(firstSlotEvent), .fifoFlush(fifoFlush), .irq(irq));
    initial begin
        forever #20 clk = ~clk;
    end
    // one clock of stimulus: e = {pop, push, second, first}
    task st(input logic w, r, input logic [7:0] a, input logic [15:0] d, input logic [3:0] e);
        {regWrite, regRead, regAddr, regWdata} = {w, r, a, d};
        {fifoPop, fifoPush, secondSlotEvent, firstSlotEvent} = e;
        @(negedge clk);
    endtask
    task chk(input string s, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task complete_run;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            complete_run;
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        reset = 0;
        st(0, 1, 8'h01, 0, 0); chk("mask", 16'h01FF, regRdata);
        n = 2 + {$random(seed)} % 40;
        repeat (n) st(0, 0, 8'h00, 0, 4'h4);
        st(1, 0, 8'h06, 16'((n / 2 - 1) << 8), 0);
        st(1, 0, 8'h01, 16'h00FF, 0); chk("irq", 1, irq);
        st(0, 1, 8'h00, 0, 0); chk("cnt", n[15:0], {8'h00, regRdata[15:8]});
        repeat (2) st(0, 0, 8'h00, 0, 4'h8);
        chk("irq", 0, irq);
        st(1, 0, 8'h00, 16'h8000, 0); chk("flush", 1, {15'h0000, fifoFlush});
        st(0, 1, 8'h00, 0, 0); chk("stat", 0, regRdata);
        chk("flush", 0, {15'h0000, fifoFlush});
        st(0, 0, 8'h00, 0, 4'h8); st(0, 1, 8'h00, 0, 0); chk("cnt", 0, regRdata);
        st(0, 0, 8'h00, 0, 4'h3); st(0, 1, 8'h00, 0, 0); chk("stat", 16'h0060, regRdata);
        st(1, 0, 8'h01, 16'h01DF, 0); chk("irq", 1, irq);
        st(1, 0, 8'h00, 16'h0040, 0); st(0, 1, 8'h00, 0, 0); chk("stat", 16'h0020, regRdata);
        st(1, 0, 8'h00, 0, 0); chk("irq", 1, irq);
        st(1, 0, 8'h00, 16'h0020, 0); chk("irq", 0, irq);
        st(0, 0, 8'h00, 0, 4'h2); chk("irq", 0, irq);
        st(1, 0, 8'h01, 16'h01BF, 0); chk("irq", 1, irq);
        st(1, 0, 8'h00, 16'h009F, 0); st(0, 1, 8'h00, 0, 0); chk("stat", 16'h0040, regRdata);
        st(0, 1, 8'h02, 0, 0); chk("unmap", 0, regRdata);
        complete_run;
    end
endmodule // fsirq_status_tb
`default_nettype wire
